// *** core/csd_pkg.sv ***
package csd_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register byte addresses
    localparam int          CSD_RANGES         = 4;
    localparam int          CSD_SPACES         = 3;
    localparam logic [31:0] CSD_ADR_RANGE0     = 32'hFFFF_E400;
    localparam logic [31:0] CSD_ADR_RANGE1     = 32'hFFFF_E404;
    localparam logic [31:0] CSD_ADR_RANGE2     = 32'hFFFF_E408;
    localparam logic [31:0] CSD_ADR_RANGE3     = 32'hFFFF_E40C;
    localparam logic [31:0] CSD_ADR_SPACE01    = 32'hFFFF_E480;
    localparam logic [31:0] CSD_ADR_SPACE23    = 32'hFFFF_E484;
    localparam logic [31:0] CSD_ADR_OTHER      = 32'hFFFF_E488;
    localparam logic [31:0] CSD_ADR_STATUS     = 32'hFFFF_E48C;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [31:0] CSD_RST_RANGE01    = 32'h0000_03FF;
    localparam logic [31:0] CSD_RST_RANGE23    = 32'h0000_01FF;
    localparam logic [31:0] CSD_RST_CONTROL    = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////////
    // range register fields
    localparam int          CSD_BASE_LSB       = 16;
    localparam int          CSD_FIELD_W        = 16;
    localparam int          CSD_MASK_ADDR_01   = 14;
    localparam int          CSD_MASK_ADDR_23   = 15;

    ////////////////////////////////////////////////////////////////////////////////
    // control register fields
    localparam int          CSD_CTL_EN_BIT     = 0;
    localparam int          CSD_CTL_WIDTH_BIT  = 1;
    localparam int          CSD_CTL_WAIT_LSB   = 2;
    localparam int          CSD_CTL_WAIT_W     = 3;
    localparam int          CSD_CTL_DUMMY_LSB  = 5;
    localparam int          CSD_CTL_DUMMY_W    = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // status register fields
    localparam int          CSD_ST_SEL_LSB     = 0;
    localparam int          CSD_ST_BUSY_BIT    = 4;
    localparam int          CSD_ST_DMA_BIT     = 5;
    localparam int          CSD_ST_WAIT_BIT    = 6;

    typedef enum logic [2:0] {
        CSD_IDLE,
        CSD_T1,
        CSD_T2,
        CSD_T3,
        CSD_DUMMY
    } csd_state_t;

endpackage

// *** core/csd_sync2.sv ***
`timescale 1ns/1ps
module csd_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_rst,
    // data
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] stage1;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("csd_sync2: WIDTH must be at least 1");
        end
    endgenerate

    // idle level of the active-low pins is high
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            stage1 <= '1;
            o_sync <= '1;
        end else begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end
endmodule

// *** core/csd_range_match.sv ***
`timescale 1ns/1ps
module csd_range_match
    import csd_pkg::*;
#(
    parameter int MASK_ADDR_LSB = CSD_MASK_ADDR_01
) (
    // address under test
    input  wire logic [31:0] i_addr,
    // range register contents
    input  wire logic [31:0] i_base_mask,
    // result
    output logic             o_hit
);
    logic [31:0] base_full;
    logic [31:0] mask_full;
    logic [31:0] care;

    generate
        if (MASK_ADDR_LSB < CSD_BASE_LSB - 2 || MASK_ADDR_LSB + CSD_FIELD_W > 31) begin : g_bad
            $error("csd_range_match: MASK_ADDR_LSB out of range");
        end
    endgenerate

    always_comb begin
        base_full = {i_base_mask[CSD_BASE_LSB +: CSD_FIELD_W], 16'h0000};
        mask_full = {16'h0000, i_base_mask[CSD_FIELD_W-1:0]} << MASK_ADDR_LSB;
        // bits under the granule never compared, top bits always compared
        care      = (32'hFFFF_FFFF << MASK_ADDR_LSB) & ~mask_full;
        o_hit     = ((i_addr ^ base_full) & care) == 32'h0000_0000;
    end
endmodule

// *** core/csd_decoder.sv ***
`timescale 1ns/1ps
module csd_decoder
    import csd_pkg::*;
(
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    // wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [31:0] i_wb_adr,
    input  wire logic [31:0] i_wb_dat,
    input  wire logic [3:0]  i_wb_sel,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    // cpu external request
    input  wire logic        i_cpu_req,
    input  wire logic [31:0] i_cpu_addr,
    input  wire logic        i_cpu_write,
    output logic             o_cpu_done,
    // dma controller external request
    input  wire logic        i_dma_req,
    input  wire logic [31:0] i_dma_addr,
    input  wire logic        i_dma_write,
    output logic             o_dma_done,
    // external bus pins
    input  wire logic        i_ext_wait_n,
    output logic      [3:0]  o_range_select_n,
    output logic             o_read_n,
    output logic             o_write_n,
    output logic             o_bus_width16,
    output logic             o_bus_busy
);

    ////////////////////////////////////////////////////////////////////////////////
    // declarations
    logic [31:0]                range_base_mask_reg [CSD_RANGES];
    logic [31:0]                control_reg [CSD_SPACES];
    logic                       wb_take;
    logic [31:0]                next_wb_dat;
    logic                       ext_wait_sync_n;

    logic                       pick_valid;
    logic                       pick_dma;
    logic [31:0]                pick_addr;
    logic                       pick_write;
    logic [CSD_RANGES-1:0]      range_hit;
    logic [CSD_RANGES-1:0]      first_hit;
    logic [31:0]                space_ctl;

    csd_state_t                 state;
    logic                       cur_dma;
    logic                       cur_write;
    logic [CSD_CTL_WAIT_W-1:0]  wait_cnt;
    logic [CSD_CTL_DUMMY_W-1:0] dummy_cnt;

    ////////////////////////////////////////////////////////////////////////////////
    // wait pin synchroniser
    csd_sync2 #(
        .WIDTH (1)
    ) u_wait_sync (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_async (i_ext_wait_n),
        .o_sync  (ext_wait_sync_n)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // wishbone handshake: ack one cycle after the strobe, dropped the next cycle
    assign wb_take = i_wb_cyc && i_wb_stb && !o_wb_ack;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_wb_ack <= 1'b0;
        end else begin
            o_wb_ack <= wb_take;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register file writes, byte lanes honoured
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            range_base_mask_reg[0] <= CSD_RST_RANGE01;
            range_base_mask_reg[1] <= CSD_RST_RANGE01;
            range_base_mask_reg[2] <= CSD_RST_RANGE23;
            range_base_mask_reg[3] <= CSD_RST_RANGE23;
            for (int s = 0; s < CSD_SPACES; s++) begin
                control_reg[s] <= CSD_RST_CONTROL;
            end
        end else if (wb_take && i_wb_we) begin
            for (int b = 0; b < 4; b++) begin
                if (i_wb_sel[b]) begin
                    unique case (i_wb_adr)
                        CSD_ADR_RANGE0:  range_base_mask_reg[0][b*8 +: 8] <= i_wb_dat[b*8 +: 8];
                        CSD_ADR_RANGE1:  range_base_mask_reg[1][b*8 +: 8] <= i_wb_dat[b*8 +: 8];
                        CSD_ADR_RANGE2:  range_base_mask_reg[2][b*8 +: 8] <= i_wb_dat[b*8 +: 8];
                        CSD_ADR_RANGE3:  range_base_mask_reg[3][b*8 +: 8] <= i_wb_dat[b*8 +: 8];
                        CSD_ADR_SPACE01: control_reg[0][b*8 +: 8] <= i_wb_dat[b*8 +: 8];
                        CSD_ADR_SPACE23: control_reg[1][b*8 +: 8] <= i_wb_dat[b*8 +: 8];
                        CSD_ADR_OTHER:   control_reg[2][b*8 +: 8] <= i_wb_dat[b*8 +: 8];
                        // status and unmapped words swallow the write
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data mux
    always_comb begin
        next_wb_dat = 32'h0000_0000;
        unique case (i_wb_adr)
            CSD_ADR_RANGE0:  next_wb_dat = range_base_mask_reg[0];
            CSD_ADR_RANGE1:  next_wb_dat = range_base_mask_reg[1];
            CSD_ADR_RANGE2:  next_wb_dat = range_base_mask_reg[2];
            CSD_ADR_RANGE3:  next_wb_dat = range_base_mask_reg[3];
            CSD_ADR_SPACE01: next_wb_dat = control_reg[0];
            CSD_ADR_SPACE23: next_wb_dat = control_reg[1];
            CSD_ADR_OTHER:   next_wb_dat = control_reg[2];
            CSD_ADR_STATUS: begin
                next_wb_dat[CSD_ST_SEL_LSB +: CSD_RANGES] = ~o_range_select_n;
                next_wb_dat[CSD_ST_BUSY_BIT]              = o_bus_busy;
                next_wb_dat[CSD_ST_DMA_BIT]               = cur_dma;
                next_wb_dat[CSD_ST_WAIT_BIT]              = ~ext_wait_sync_n;
            end
            default: next_wb_dat = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_wb_dat <= 32'h0000_0000;
        end else if (wb_take) begin
            o_wb_dat <= i_wb_we ? 32'h0000_0000 : next_wb_dat;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // request pick: dma first, since it usually has tighter latency needs
    always_comb begin
        pick_valid = i_dma_req || i_cpu_req;
        pick_dma   = i_dma_req;
        pick_addr  = i_dma_req ? i_dma_addr : i_cpu_addr;
        pick_write = i_dma_req ? i_dma_write : i_cpu_write;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // range comparators, one per select line
    generate
        for (genvar k = 0; k < CSD_RANGES; k++) begin : g_range
            csd_range_match #(
                .MASK_ADDR_LSB ((k < 2) ? CSD_MASK_ADDR_01 : CSD_MASK_ADDR_23)
            ) u_match (
                .i_addr      (pick_addr),
                .i_base_mask (range_base_mask_reg[k]),
                .o_hit       (range_hit[k])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // overlapping ranges: the lowest numbered select wins
    always_comb begin
        first_hit = '0;
        for (int k = CSD_RANGES - 1; k >= 0; k--) begin
            if (range_hit[k]) begin
                first_hit    = '0;
                first_hit[k] = 1'b1;
            end
        end
        if (first_hit[0] || first_hit[1]) begin
            space_ctl = control_reg[0];
        end else if (first_hit[2] || first_hit[3]) begin
            space_ctl = control_reg[1];
        end else begin
            space_ctl = control_reg[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // external bus cycle: T1 address, T2 strobe plus waits, T3 finish, then recovery after reads
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state            <= CSD_IDLE;
            cur_dma          <= 1'b0;
            cur_write        <= 1'b0;
            wait_cnt         <= '0;
            dummy_cnt        <= '0;
            o_range_select_n <= 4'hF;
            o_read_n         <= 1'b1;
            o_write_n        <= 1'b1;
            o_bus_width16    <= 1'b0;
            o_bus_busy       <= 1'b0;
            o_cpu_done       <= 1'b0;
            o_dma_done       <= 1'b0;
        end else begin
            o_cpu_done <= 1'b0;
            o_dma_done <= 1'b0;
            unique case (state)
                CSD_IDLE: begin
                    if (pick_valid) begin
                        // decode taken from the live address, never a stale result
                        state            <= CSD_T1;
                        cur_dma          <= pick_dma;
                        cur_write        <= pick_write;
                        o_range_select_n <= ~(first_hit
                                            & {CSD_RANGES{space_ctl[CSD_CTL_EN_BIT]}});
                        o_bus_width16    <= space_ctl[CSD_CTL_WIDTH_BIT];
                        wait_cnt         <= space_ctl[CSD_CTL_WAIT_LSB +: CSD_CTL_WAIT_W];
                        dummy_cnt        <= space_ctl[CSD_CTL_DUMMY_LSB +: CSD_CTL_DUMMY_W];
                        o_bus_busy       <= 1'b1;
                    end
                end
                CSD_T1: begin
                    state     <= CSD_T2;
                    o_read_n  <= cur_write;
                    o_write_n <= !cur_write;
                end
                CSD_T2: begin
                    if (wait_cnt != '0) begin
                        wait_cnt <= wait_cnt - 1'b1;
                    end else if (ext_wait_sync_n) begin
                        // done shows during T3 so the master drops its request in time
                        state      <= CSD_T3;
                        o_cpu_done <= !cur_dma;
                        o_dma_done <= cur_dma;
                    end
                    // wait pin low keeps the cycle in T2
                end
                CSD_T3: begin
                    o_read_n         <= 1'b1;
                    o_write_n        <= 1'b1;
                    o_range_select_n <= 4'hF;
                    // recovery only after reads; a write needs none
                    if (!cur_write && dummy_cnt != '0) begin
                        state <= CSD_DUMMY;
                    end else begin
                        state      <= CSD_IDLE;
                        o_bus_busy <= 1'b0;
                    end
                end
                CSD_DUMMY: begin
                    if (dummy_cnt <= 2'h1) begin
                        state      <= CSD_IDLE;
                        o_bus_busy <= 1'b0;
                    end else begin
                        dummy_cnt <= 2'h1;
                    end
                end
                default: begin
                    state <= CSD_IDLE;
                end
            endcase
        end
    end

endmodule

// *** bench/csd_decoder_assertions.sv ***
`timescale 1ns/1ps
module csd_decoder_checker (
    // clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    // register bus
    input  wire logic       i_wb_cyc,
    input  wire logic       i_wb_stb,
    input  wire logic       o_wb_ack,
    // requesters
    input  wire logic       i_cpu_req,
    input  wire logic       i_dma_req,
    input  wire logic       o_cpu_done,
    input  wire logic       o_dma_done,
    // external pins
    input  wire logic [3:0] o_range_select_n,
    input  wire logic       o_read_n,
    input  wire logic       o_write_n,
    input  wire logic       o_bus_busy
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    ////////////////////////////////////////////////////////////////////////////////
    // external cycle
    property p_sel_onehot; $onehot0(~o_range_select_n); endproperty
    a_sel_onehot: assert property (p_sel_onehot) else $error("two selects low");
    property p_sel_busy; (o_range_select_n != 4'hF) |-> o_bus_busy; endproperty
    a_sel_busy: assert property (p_sel_busy) else $error("select outside cycle");
    property p_take; (!o_bus_busy && (i_cpu_req || i_dma_req)) |=> o_bus_busy; endproperty
    a_take: assert property (p_take) else $error("request not taken");
    property p_sel_hold; (!o_read_n && $past(!o_read_n)) |-> $stable(o_range_select_n);
    endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("select moved in cycle");
    property p_free; $fell(o_bus_busy) |-> (o_range_select_n == 4'hF) && o_read_n && o_write_n;
    endproperty
    a_free: assert property (p_free) else $error("pins not released");
    property p_strobe_busy; (!o_read_n || !o_write_n) |-> o_bus_busy && (o_read_n || o_write_n);
    endproperty
    a_strobe_busy: assert property (p_strobe_busy) else $error("bad strobe");
    property p_done_strobe;
        (o_cpu_done || o_dma_done) |-> (!o_read_n || !o_write_n) ##1 !(o_cpu_done || o_dma_done);
    endproperty
    a_done_strobe: assert property (p_done_strobe) else $error("bad done pulse");

    ////////////////////////////////////////////////////////////////////////////////
    // register bus
    property p_ack_cause; o_wb_ack |-> $past(i_wb_cyc && i_wb_stb); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without strobe");
    property p_ack_pulse; o_wb_ack |=> !o_wb_ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
endmodule

bind csd_decoder csd_decoder_checker u_csd_decoder_checker (
    .i_clock, .i_rst, .i_wb_cyc, .i_wb_stb, .o_wb_ack, .i_cpu_req, .i_dma_req, .o_cpu_done,
    .o_dma_done, .o_range_select_n, .o_read_n, .o_write_n, .o_bus_busy
);

// *** bench/csd_ext_device.sv ***
`timescale 1ns/1ps
module csd_ext_device (
    // clock
    input  wire logic       i_clock,
    // bus pins
    input  wire logic [3:0] i_range_select_n,
    input  wire logic       i_read_n,
    input  wire logic       i_write_n,
    // stretch commanded by the bench, 0 = answer promptly
    input  wire logic [3:0] i_stretch,
    // wait pin
    output logic            o_wait_n
);
    logic [3:0] left;
    logic       armed;

    initial begin
        o_wait_n = 1'b1;
        left     = 4'h0;
        armed    = 1'b0;
    end

    // one stretch per selected cycle, re-armed only once selects are idle
    always @(posedge i_clock) begin
        if (i_range_select_n == 4'hF) armed <= 1'b1;
        if (armed && i_range_select_n != 4'hF && !(i_read_n && i_write_n) && i_stretch != 0) begin
            left     <= i_stretch;
            armed    <= 1'b0;
            o_wait_n <= 1'b0;
        end else if (left > 4'h1) begin
            left <= left - 4'h1;
        end else begin
            left     <= 4'h0;
            o_wait_n <= 1'b1;
        end
    end
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    import csd_pkg::*;
    logic        i_clock = 1'b0;
    logic        i_rst, cyc, stb, we, creq, cwr, dreq, dwr, wait_n, ack, cdone, ddone;
    logic        rd_n, wr_n, w16, busy;
    logic [31:0] adr, dat, q, caddr, daddr, rdat;
    logic [3:0]  sel, sel_n, stretch;
    int          miscompares, n_tests;
    logic [31:0] ta [9] = '{32'h0010_3FFC, 32'h0010_4000, 32'h8010_0000, 32'h0020_4000,
        32'h0020_8000, 32'h0030_FFFC, 32'h0031_0000, 32'h0040_7FFC, 32'h0040_8000};
    logic [3:0]  ts [9] = '{4'hE, 4'hF, 4'hF, 4'hD, 4'hF, 4'hB, 4'hF, 4'h7, 4'hF};

    always #10 i_clock = ~i_clock;

    csd_decoder u_csd_decoder (.i_clock(i_clock), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(dat), .i_wb_sel(sel), .o_wb_dat(q),
        .o_wb_ack(ack), .i_cpu_req(creq), .i_cpu_addr(caddr), .i_cpu_write(cwr),
        .o_cpu_done(cdone), .i_dma_req(dreq), .i_dma_addr(daddr), .i_dma_write(dwr),
        .o_dma_done(ddone), .i_ext_wait_n(wait_n), .o_range_select_n(sel_n), .o_read_n(rd_n),
        .o_write_n(wr_n), .o_bus_width16(w16), .o_bus_busy(busy));
    csd_ext_device u_csd_ext_device (.i_clock(i_clock), .i_range_select_n(sel_n),
        .i_read_n(rd_n), .i_write_n(wr_n), .i_stretch(stretch), .o_wait_n(wait_n));

    ////////////////////////////////////////////////////////////////////////////////
    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task report_and_stop;
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // classic single cycle, held until ack is sampled
    task wb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge i_clock);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
        do @(posedge i_clock); while (ack !== 1'b1);
        rdat = q;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask

    task wb_chk(input logic [31:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0000_0000);
        check($sformatf("reg %h", a), e, rdat);
    endtask

    // expected figures come from the caller, counted in cycles after the take edge
    task ext(input logic d, input logic w, input logic [31:0] a, input logic [3:0] es,
             input logic ew, input int lo, input int hi);
        int n;
        @(posedge i_clock);
        if (d) begin dreq <= 1'b1; daddr <= a; dwr <= w; end
        else begin creq <= 1'b1; caddr <= a; cwr <= w; end
        @(posedge i_clock);
        #1;
        check($sformatf("select %h", a), es, sel_n);
        n = 0;
        while ((d ? ddone : cdone) !== 1'b1 && n < 40) begin @(posedge i_clock); #1; n++; end
        check("cycles", (n >= lo && n <= hi) ? n : lo, n);
        check("strobes", {w, !w}, {rd_n, wr_n});
        check("width", ew, w16);
        check("select held", es, sel_n);
        @(posedge i_clock);
        creq <= 1'b0; dreq <= 1'b0;
        #1;
        while (busy !== 1'b0) begin @(posedge i_clock); #1; end
        check("released", 6'h3F, {sel_n, rd_n, wr_n});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #100us;
        miscompares++;
        report_and_stop;
    end

    initial begin
        i_rst = 1'b1; cyc = 0; stb = 0; we = 0; adr = 0; dat = 0; sel = 0; stretch = 0;
        creq = 0; cwr = 0; caddr = 0; dreq = 0; dwr = 0; daddr = 0;
        repeat (2) @(posedge i_clock);
        i_rst <= 1'b0;
        for (int i = 0; i < 4; i++)
            wb_chk(CSD_ADR_RANGE0 + 4 * i, i < 2 ? CSD_RST_RANGE01 : CSD_RST_RANGE23);
        for (int i = 0; i < 3; i++) wb_chk(CSD_ADR_SPACE01 + 4 * i, CSD_RST_CONTROL);
        wb(1'b1, CSD_ADR_STATUS, 32'hFFFF_FFFF);
        wb_chk(CSD_ADR_STATUS, 32'h0000_0000);
        wb(1'b1, 32'hFFFF_E490, 32'h1234_5678);
        wb_chk(32'hFFFF_E490, 32'h0000_0000);
        $display("test reset and access done");
        // physical addresses, upper mask bits kept zero
        wb(1'b1, CSD_ADR_RANGE0, 32'h0010_0000);
        wb(1'b1, CSD_ADR_RANGE1, 32'h0020_0001);
        wb(1'b1, CSD_ADR_RANGE2, 32'h0030_0001);
        wb(1'b1, CSD_ADR_RANGE3, 32'h0040_0000);
        wb(1'b1, CSD_ADR_SPACE01, 32'h0000_0003);
        wb(1'b1, CSD_ADR_SPACE23, 32'h0000_0001);
        wb(1'b1, CSD_ADR_OTHER, 32'h0000_007C);
        wb_chk(CSD_ADR_RANGE1, 32'h0020_0001);
        wb_chk(CSD_ADR_OTHER, 32'h0000_007C);
        // misses run with the other space: 7 waits, width 8
        for (int i = 0; i < 9; i++)
            ext(i[0], i[1], ta[i], ts[i], ts[i] == 4'hE || ts[i] == 4'hD,
                ts[i] == 4'hF ? 9 : 2, ts[i] == 4'hF ? 9 : 2);
        $display("test range decode done");
        wb(1'b1, CSD_ADR_SPACE01, 32'h0000_002B);
        ext(1'b0, 1'b0, 32'h0010_0000, 4'hE, 1'b1, 4, 4);
        ext(1'b1, 1'b1, 32'h0020_0000, 4'hD, 1'b1, 4, 4);
        wb(1'b1, CSD_ADR_RANGE0, 32'h0050_0000);
        ext(1'b0, 1'b0, 32'h0010_0000, 4'hF, 1'b0, 9, 9);
        ext(1'b0, 1'b1, 32'h0050_0000, 4'hE, 1'b1, 4, 4);
        wb(1'b1, CSD_ADR_SPACE23, 32'h0000_0000);
        // a disabled hit keeps its own space timing, only the select is gated
        ext(1'b1, 1'b0, 32'h0040_0000, 4'hF, 1'b0, 2, 2);
        $display("test control spaces done");
        // pin reaches the cycle two edges late, so three auto waits must cover it
        wb(1'b1, CSD_ADR_SPACE01, 32'h0000_000F);
        stretch <= 4'h3;
        ext(1'b0, 1'b0, 32'h0050_0000, 4'hE, 1'b1, 8, 8);
        ext(1'b1, 1'b1, 32'h0020_4000, 4'hD, 1'b1, 8, 8);
        stretch <= 4'h0;
        ext(1'b0, 1'b0, 32'h0050_0000, 4'hE, 1'b1, 5, 5);
        $display("test wait pin done");
        report_and_stop;
    end
endmodule
